// ---- design/pfl_sync.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pfl_sync
#(
    parameter         W   = 1,
    parameter [W-1:0] RST = {W{1'b0}} // level both stages hold in reset
)
(
    input  wire         i_clk,
    input  wire         i_sys_rst,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync
);
    reg [W-1:0] meta_q; // first stage, read only by second stage

    // both stages reset to the idle level of their pins
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            meta_q <= RST;
            o_sync <= RST;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ---- design/pfl_timer.v ----
// down counter that pulses done once after load
`timescale 1ns/100ps
module pfl_timer
#(
    parameter W = 16
)
(
    input  wire         i_clk,
    input  wire         i_sys_rst,
    input  wire         i_load,
    input  wire [W-1:0] i_count,
    input  wire         i_run,
    output reg          o_done
);
    reg [W-1:0] cnt_q; // cycles left

    // load restarts; run low aborts; done pulses at zero
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cnt_q  <= {W{1'b0}};
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_load)
                cnt_q <= i_count;
            else if (!i_run)
                cnt_q <= {W{1'b0}};
            else if (cnt_q != {W{1'b0}})
            begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                if (cnt_q == {{(W-1){1'b0}}, 1'b1})
                    o_done <= 1'b1;
            end
        end
    end
endmodule

// ---- design/power_fail_lockout_ctrl.v ----
// power-fail supervision, bus lockout and battery standby control
`timescale 1ns/100ps
`include "pfl_consts.vh"
module power_fail_lockout_ctrl
#(
    parameter DEB_CYC   = `DEBOUNCE_CYC,
    parameter GRACE_CYC = `GRACE_CYC,
    parameter HOLD_CYC  = `HOLD_CYC,
    parameter TW        = 16
)
(
    input  wire       i_clk,
    input  wire       i_sys_rst,
    input  wire       i_power_loss_n,
    input  wire       i_battery_supply,
    input  wire       i_battery_low,
    input  wire       i_cs_n,
    input  wire       i_rd_n,
    input  wire       i_wr_n,
    input  wire [4:0] i_addr_lines,
    input  wire [7:0] i_data_lines,
    input  wire [7:0] i_clock_count,
    input  wire       i_timer_clk,
    input  wire       i_gate_in_zero,
    input  wire       i_gate_in_one,
    input  wire       i_irq_src,
    output reg  [7:0] o_data_lines,
    output reg        o_data_oe_n,
    output reg        o_irq_out,
    output reg        o_irq_od,
    output reg        o_multifunction_od,
    output reg        o_timer_one_od,
    output reg        o_timer_clk,
    output reg        o_gate_in_zero,
    output reg        o_gate_in_one,
    output reg        o_lockout,
    output reg        o_timers_run,
    output reg        o_ints_run,
    output reg        o_detector_on
);
    // ****************************************************
    // state encodings
    // ****************************************************
    localparam [3:0] ST_OK    = 4'b0001; // bus open, power good
    localparam [3:0] ST_GRACE = 4'b0010; // failed, host still served
    localparam [3:0] ST_LOCK  = 4'b0100; // bus locked out
    localparam [3:0] ST_REST  = 4'b1000; // input high, debouncing

    // ****************************************************
    // synchronised pins
    // ****************************************************
    wire [30:0] pins_s;    // synchronised pins and bus lines
    wire       ploss_n_s;  // power-loss input
    wire       batt_s;     // battery standby comparator
    wire       blow_s;     // low battery comparator
    wire       cs_n_s;     // chip select
    wire       rd_n_s;     // read strobe
    wire       wr_n_s;     // write strobe
    wire       tclk_s;     // external timer clock
    wire       g0_s;       // gate zero
    wire       g1_s;       // gate one
    wire       isrc_s;     // interrupt source from timers
    wire [4:0] addr_s;     // register address
    wire [7:0] wdat_s;     // write data
    wire [7:0] ccnt_s;     // clock counter contents

    pfl_sync #(.W(31), .RST(`PIN_IDLE)) u_sync
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_power_loss_n, i_battery_supply, i_battery_low,
                     i_cs_n, i_rd_n, i_wr_n, i_timer_clk,
                     i_gate_in_zero, i_gate_in_one, i_irq_src,
                     i_addr_lines, i_data_lines, i_clock_count}),
        .o_sync    (pins_s)
    );
    assign {ploss_n_s, batt_s, blow_s, cs_n_s, rd_n_s, wr_n_s,
            tclk_s, g0_s, g1_s, isrc_s, addr_s, wdat_s, ccnt_s} = pins_s;

    // ****************************************************
    // registers
    // ****************************************************
    reg [3:0] state_q;      // lockout state machine
    reg [3:0] state_d;
    reg [7:0] routing_q;    // interrupt routing register
    reg [7:0] rtmode_q;     // real-time mode register
    reg [7:0] ctrl1_q;      // interrupt control register 1
    reg [7:0] tsave_q;      // time save storage
    reg       osc_fail_q;   // oscillator-fail flag
    reg       low_bat_q;    // low battery status
    reg       pf_q;         // internal power-failed signal
    reg       cs_at_pf_q;   // chip select was low at detection
    reg       wr_n_d1_q;    // delayed write strobe for edge
    reg [7:0] rd_mux;       // read data selection

    // ****************************************************
    // debounce and hold timers
    // ****************************************************
    wire deb_want  = (state_q == ST_OK) ? ~ploss_n_s
                   : (state_q == ST_REST) ? ploss_n_s : 1'b0;
    reg  deb_arm_q; // timer armed for current level
    wire deb_done;
    wire grace_done;
    wire hold_done;
    wire strobe_on  = ~rd_n_s | ~wr_n_s;

    // restart debounce whenever deb_want rises
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            deb_arm_q <= 1'b0;
        else
            deb_arm_q <= deb_want;
    end

    pfl_timer #(.W(TW)) u_deb
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (deb_want & ~deb_arm_q),
        .i_count   (DEB_CYC[TW-1:0]),
        .i_run     (deb_want),
        .o_done    (deb_done)
    );

    pfl_timer #(.W(TW)) u_grace
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (state_q == ST_OK && state_d == ST_GRACE),
        .i_count   (GRACE_CYC[TW-1:0]),
        .i_run     (state_q == ST_GRACE),
        .o_done    (grace_done)
    );

    // hold timer watches a strobe raised in grace after chip select was low at detection
    reg hold_arm_q;
    wire hold_want = pf_q & cs_at_pf_q & strobe_on & (state_q == ST_GRACE);
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            hold_arm_q <= 1'b0;
        else
            hold_arm_q <= hold_want;
    end

    pfl_timer #(.W(TW)) u_hold
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_load    (hold_want & ~hold_arm_q),
        .i_count   (HOLD_CYC[TW-1:0]),
        .i_run     (hold_want),
        .o_done    (hold_done)
    );

    // ****************************************************
    // lockout state machine
    // ****************************************************
    // an access in flight when the debounce ends cancels that detection
    wire in_access = ~cs_n_s & strobe_on;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_OK:
                if (deb_done & ~in_access)
                    state_d = routing_q[`RT_DELAY_EN] ? ST_GRACE
                                                      : ST_LOCK;
            ST_GRACE:
                if (grace_done | ~routing_q[`RT_DELAY_EN] | hold_done)
                    state_d = ST_LOCK;
            ST_LOCK:
                if (ploss_n_s)
                    state_d = ST_REST;
            ST_REST:
                if (!ploss_n_s)
                    state_d = ST_LOCK;
                else if (deb_done)
                    state_d = ST_OK;
            default:
                state_d = ST_LOCK;
        endcase
    end

    // state and power-failed signal
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q    <= ST_OK;
            pf_q       <= 1'b0;
            cs_at_pf_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_OK && state_d != ST_OK)
            begin
                pf_q       <= 1'b1;
                cs_at_pf_q <= ~cs_n_s;
            end
            else if (state_d == ST_OK)
                pf_q <= 1'b0;
        end
    end

    wire locked  = (state_q == ST_LOCK) | (state_q == ST_REST);
    wire bus_off = locked | batt_s;
    wire sel     = ~cs_n_s & ~bus_off;

    // ****************************************************
    // register writes, discarded while locked
    // ****************************************************
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            routing_q  <= `ROUTING_RST;
            rtmode_q   <= `RTM_RST;       // clock start cleared
            ctrl1_q    <= `C1_RST;
            tsave_q    <= `ZERO8;
            osc_fail_q <= 1'b1;
            low_bat_q  <= 1'b0;
            wr_n_d1_q  <= 1'b1;
        end
        else
        begin
            wr_n_d1_q <= wr_n_s;
            if (sel & ~wr_n_s & wr_n_d1_q)
            begin
                case (addr_s)
                    `ADDR_ROUTING: routing_q <= wdat_s;
                    `ADDR_RT_MODE: rtmode_q  <= wdat_s;
                    `ADDR_CTRL1:   ctrl1_q   <= wdat_s;
                    // writing D6 leaves osc-fail alone
                    default:       ;
                endcase
            end
            // osc-fail clears only once clock is started
            if (rtmode_q[`RTM_START])
                osc_fail_q <= 1'b0;
            // battery switch clears time save enable
            if (batt_s)
                rtmode_q[`RTM_TSAVE_EN] <= 1'b0;
            // copy clock while save enabled
            if (rtmode_q[`RTM_TSAVE_EN] & ~batt_s)
                tsave_q <= ccnt_s;
            // low battery on main supply and enabled
            if (ctrl1_q[`C1_PF_IE] & ~batt_s)
                low_bat_q <= blow_s;
        end
    end

    // read data selection
    always @*
    begin
        case (addr_s)
            `ADDR_MAIN_STATUS: rd_mux = {6'h00,
                                (pf_q & ctrl1_q[`C1_PF_IE]), o_irq_out};
            `ADDR_PERIODIC:    rd_mux = {1'b0, osc_fail_q, 6'h00};
            `ADDR_ROUTING:     rd_mux = routing_q;
            `ADDR_RT_MODE:     rd_mux = rtmode_q;
            `ADDR_CTRL1:       rd_mux = {ctrl1_q[7:1], low_bat_q};
            `ADDR_TSAVE:       rd_mux = tsave_q;
            default:           rd_mux = `ZERO8;
        endcase
    end

    // ****************************************************
    // registered outputs
    // ****************************************************
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_data_lines       <= `ZERO8;
            o_data_oe_n        <= 1'b1;
            o_irq_out          <= 1'b0;
            o_irq_od           <= 1'b0;
            o_multifunction_od <= 1'b0;
            o_timer_one_od     <= 1'b0;
            o_timer_clk        <= 1'b0;
            o_gate_in_zero     <= 1'b0;
            o_gate_in_one      <= 1'b0;
            o_lockout          <= 1'b0;
            o_timers_run       <= 1'b1;
            o_ints_run         <= 1'b1;
            o_detector_on      <= 1'b0;
        end
        else
        begin
            o_data_lines <= rd_mux;
            o_data_oe_n  <= ~(sel & ~rd_n_s);
            // irq from pf or sources; pf irq needs enable
            o_irq_out    <= (pf_q & ctrl1_q[`C1_PF_IE])
                            | (isrc_s & o_ints_run);
            o_irq_od           <= batt_s;
            o_multifunction_od <= batt_s;
            o_timer_one_od     <= batt_s;
            o_timer_clk    <= tclk_s & ~batt_s;
            o_gate_in_zero <= g0_s & ~batt_s;
            o_gate_in_one  <= g1_s & ~batt_s;
            o_lockout      <= bus_off;
            o_timers_run   <= ~pf_q | rtmode_q[`RTM_TMR_PFOP];
            o_ints_run     <= ~pf_q | rtmode_q[`RTM_INT_PFOP];
            // detector off when masked or on battery
            o_detector_on  <= ctrl1_q[`C1_PF_IE] & ~batt_s;
        end
    end
endmodule

// ---- inc/pfl_consts.vh ----
// constants for the power-fail lockout controller
`ifndef PFL_CONSTS_VH
`define PFL_CONSTS_VH

// timing in clock cycles at 40 MHz (25 ns period)
`define CLK_NS            25
`define DEBOUNCE_MIN_US   30
`define DEBOUNCE_CYC      ((`DEBOUNCE_MIN_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define GRACE_US          480
`define GRACE_CYC         ((`GRACE_US * 1000) / `CLK_NS)
`define HOLD_US           30
`define HOLD_CYC          ((`HOLD_US * 1000 + `CLK_NS - 1) / `CLK_NS)

// register addresses on the 5-bit address lines
`define ADDR_MAIN_STATUS  5'h00
`define ADDR_PERIODIC     5'h03
`define ADDR_ROUTING      5'h04
`define ADDR_RT_MODE      5'h01
`define ADDR_CTRL1        5'h05
`define ADDR_TSAVE        5'h06

// routing register fields
`define RT_DELAY_EN       7
`define RT_PF_ROUTE       6
`define ROUTING_RST       8'h00

// main status fields
`define MS_IRQ            0
`define MS_PF             1

// periodic flag register fields
`define PF_OSC_FAIL       6

// real-time mode register fields
`define RTM_TSAVE_EN      3
`define RTM_START         4
`define RTM_TMR_PFOP      5
`define RTM_INT_PFOP      6
`define RTM_RST           8'h00

// control register 1 fields
`define C1_PF_IE          7
`define C1_LOW_BAT        0
`define C1_RST            8'h00

`define ZERO8             8'h00

// reset level of the synchronised pin group: power-loss and the bus
// strobes are active low, so they wake up idle and no false edge or
// phantom access follows reset
`define PIN_IDLE          31'h4E000000
`endif

// ---- tb/pfl_host_model.sv ----
// host processor model driving the parallel register bus
`timescale 1ns/100ps
module pfl_host_model
(
    input  wire       i_clk,
    input  wire [7:0] i_rd_data,
    input  wire       i_rd_oe_n,
    output reg        o_cs_n = 1'b1,
    output reg        o_rd_n = 1'b1,
    output reg        o_wr_n = 1'b1,
    output reg  [4:0] o_addr = 5'h00,
    output reg  [7:0] o_data = 8'h00
);
// ****
// bus cycles
// ****
// a write holds every line for four edges, then leaves wr_n high for
// three, so the two-stage pin sync sees one clean pulse
task wr(input [4:0] a, input [7:0] d);
begin
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_addr <= a;
    o_data <= d;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    // released lines show the inverse, never a stale value
    o_addr <= ~a;
    o_data <= ~d;
    repeat (3) @(posedge i_clk);
end
endtask
// read data is taken at the fourth edge, one past its latency
task rd(input [4:0] a, output [7:0] q, output oe_n);
begin
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    o_addr <= a;
    repeat (4) @(posedge i_clk);
    q = i_rd_data;
    oe_n = i_rd_oe_n;
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    o_addr <= ~a;
    repeat (4) @(posedge i_clk);
end
endtask
// chip select parked from before a failure, then a read strobe stuck
// low for len edges, to exercise the stuck-access guard
task stall(input [4:0] a, input int pre, input int len);
begin
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_addr <= a;
    repeat (pre) @(posedge i_clk);
    o_rd_n <= 1'b0;
    repeat (len) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    o_addr <= ~a;
    repeat (4) @(posedge i_clk);
end
endtask
endmodule

// ---- tb/pfl_monitor.sv ----
// port checker for the power-fail lockout controller
`timescale 1ns/100ps
module pfl_monitor
#(
    parameter DEB_CYC = 10
)
(
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_power_loss_n,
    input wire i_battery_supply,
    input wire i_timer_clk,
    input wire o_data_oe_n,
    input wire o_irq_od,
    input wire o_multifunction_od,
    input wire o_timer_one_od,
    input wire o_timer_clk,
    input wire o_gate_in_zero,
    input wire o_gate_in_one,
    input wire o_lockout,
    input wire o_detector_on
);
// ****
// run lengths of the raw power-loss pin
// ****
reg [15:0] low_q;  // cycles low in a row
reg [15:0] high_q; // cycles high in a row
// raw pin runs are never shorter than the synced ones, so bounds hold
always @(posedge i_clk or posedge i_sys_rst)
begin
    if (i_sys_rst)
    begin
        low_q  <= 16'h0000;
        high_q <= 16'h0000;
    end
    else
    begin
        low_q  <= i_power_loss_n ? 16'h0000 : low_q + 16'h0001;
        high_q <= i_power_loss_n ? high_q + 16'h0001 : 16'h0000;
    end
end
default clocking dc @(posedge i_clk);
endclocking
default disable iff (i_sys_rst);
AST_DEBOUNCE: assert property ($rose(o_lockout) &&
    !i_battery_supply |-> low_q >= DEB_CYC) else $error("early lock");
AST_LOCK_HELD: assert property (o_lockout &&
    !i_power_loss_n |=> o_lockout) else $error("lock dropped");
AST_UNLOCK: assert property ($fell(o_lockout) &&
    !i_battery_supply |-> high_q >= DEB_CYC) else $error("early unlock");
AST_LOCK_HIZ: assert property (o_lockout [*2]
    |-> o_data_oe_n) else $error("bus driven while locked");
AST_STBY_LOCK: assert property (i_battery_supply [*6]
    |-> o_lockout) else $error("standby not locked");
AST_STBY_OD: assert property (i_battery_supply [*6]
    |-> o_irq_od && o_multifunction_od && o_timer_one_od)
    else $error("outputs not open drain");
AST_STBY_PINS: assert property (i_battery_supply [*6]
    |-> !(o_timer_clk || o_gate_in_zero || o_gate_in_one))
    else $error("timing pins not blocked");
AST_DET_OFF: assert property (i_battery_supply [*6]
    |-> !o_detector_on) else $error("detector on in standby");
AST_PIN_PASS: assert property ((!i_battery_supply &&
    i_timer_clk) [*6] |-> o_timer_clk) else $error("timer pin lost");
endmodule
bind power_fail_lockout_ctrl pfl_monitor #(.DEB_CYC(DEB_CYC)) mon
(
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_power_loss_n(i_power_loss_n),
    .i_battery_supply(i_battery_supply), .i_timer_clk(i_timer_clk),
    .o_data_oe_n(o_data_oe_n), .o_irq_od(o_irq_od),
    .o_multifunction_od(o_multifunction_od),
    .o_timer_one_od(o_timer_one_od), .o_timer_clk(o_timer_clk),
    .o_gate_in_zero(o_gate_in_zero), .o_gate_in_one(o_gate_in_one),
    .o_lockout(o_lockout), .o_detector_on(o_detector_on)
);

// ---- tb/tb_power_fail_lockout_ctrl.sv ----
// self-checking bench for the power-fail lockout controller
`timescale 1ns/100ps
`include "pfl_consts.vh"
module tb_power_fail_lockout_ctrl;
// ****
// signals and instances
// ****
localparam DEB = 10; // shortened debounce keeps the run brief
localparam GRC = 40; // shortened grace period
reg        i_clk = 1'b0;
reg        i_sys_rst = 1'b1;
reg        i_power_loss_n = 1'b1;
reg        i_battery_supply = 1'b0;
reg        i_battery_low = 1'b0;
reg  [7:0] i_clock_count = 8'h00;
wire       i_cs_n;
wire       i_rd_n;
wire       i_wr_n;
wire [4:0] i_addr_lines;
wire [7:0] i_data_lines;
wire [7:0] o_data_lines;
wire       o_data_oe_n;
wire       o_irq_out;
wire [2:0] od; // open-drain mode flags
wire [2:0] gt; // gated timing pins
wire       o_lockout;
wire       o_detector_on;
wire       o_timers_run;
wire       o_ints_run;
int        bad_count = 0;
int        compares = 0;
int        cyc = 0;
int        n;
reg  [7:0] q;
reg        oe;
always #12.5 i_clk = ~i_clk;
power_fail_lockout_ctrl #(.DEB_CYC(DEB), .GRACE_CYC(GRC), .HOLD_CYC(10)) dut
(
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_power_loss_n(i_power_loss_n),
    .i_battery_supply(i_battery_supply), .i_battery_low(i_battery_low),
    .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
    .i_addr_lines(i_addr_lines), .i_data_lines(i_data_lines),
    .i_clock_count(i_clock_count), .i_timer_clk(1'b1),
    .i_gate_in_zero(1'b1), .i_gate_in_one(1'b1), .i_irq_src(1'b0),
    .o_data_lines(o_data_lines), .o_data_oe_n(o_data_oe_n),
    .o_irq_out(o_irq_out), .o_irq_od(od[0]), .o_multifunction_od(od[1]),
    .o_timer_one_od(od[2]), .o_timer_clk(gt[0]), .o_gate_in_zero(gt[1]),
    .o_gate_in_one(gt[2]), .o_lockout(o_lockout),
    .o_timers_run(o_timers_run), .o_ints_run(o_ints_run),
    .o_detector_on(o_detector_on)
);
pfl_host_model host
(
    .i_clk(i_clk), .i_rd_data(o_data_lines), .i_rd_oe_n(o_data_oe_n),
    .o_cs_n(i_cs_n), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n),
    .o_addr(i_addr_lines), .o_data(i_data_lines)
);
// ****
// helpers
// ****
task chk(input string nm, input [7:0] e, input [7:0] g);
begin
    compares = compares + 1;
    if (g !== e)
    begin
        $display("Error %s expected %h seen %h", nm, e, g);
        bad_count = bad_count + 1;
    end
end
endtask
task rchk(input [4:0] a, input [7:0] e, input [7:0] m, input string nm);
begin
    host.rd(a, q, oe);
    chk("oe_n", 8'h00, {7'h00, oe});
    chk(nm, e, q & m);
end
endtask
// counts falling edges until the lock flag reaches v, bounded by mx
task wait_lock(input bit v, input int mx);
begin
    n = 0;
    while (o_lockout !== v && n < mx)
    begin
        @(negedge i_clk);
        n = n + 1;
    end
end
endtask
task complete_run;
begin
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
// ****
// scenarios
// ****
task t_reset;
begin
    rchk(`ADDR_ROUTING, `ROUTING_RST, 8'hFF, "routing");
    rchk(`ADDR_PERIODIC, 8'h40, 8'h40, "osc_fail");
    rchk(`ADDR_RT_MODE, 8'h00, 8'h10, "start");
    host.wr(`ADDR_PERIODIC, 8'h00);
    rchk(`ADDR_PERIODIC, 8'h40, 8'h40, "osc_kept");
    host.wr(`ADDR_RT_MODE, 8'h10);
    rchk(`ADDR_PERIODIC, 8'h00, 8'h40, "osc_clr");
    $display("done t_reset");
end
endtask
task t_standby;
begin
    @(posedge i_clk) i_clock_count <= 8'h5A;
    host.wr(`ADDR_RT_MODE, 8'h18);
    rchk(`ADDR_TSAVE, 8'h5A, 8'hFF, "tsave");
    chk("pins_on", 8'h07, gt);
    host.wr(`ADDR_CTRL1, 8'h80);
    chk("det_on", 1, o_detector_on);
    @(posedge i_clk) i_battery_supply <= 1'b1;
    repeat (8) @(negedge i_clk);
    chk("stby_lock", 1, o_lockout);
    chk("od", 8'h07, od);
    chk("pins_off", 0, gt);
    chk("det", 0, o_detector_on);
    @(posedge i_clk) i_clock_count <= 8'hA5;
    i_battery_supply <= 1'b0;
    repeat (8) @(negedge i_clk);
    chk("main", 0, o_lockout);
    rchk(`ADDR_RT_MODE, 8'h10, 8'h18, "tsave_en");
    rchk(`ADDR_TSAVE, 8'h5A, 8'hFF, "tsave_frz");
    $display("done t_standby");
end
endtask
task t_lowbat;
begin
    host.wr(`ADDR_CTRL1, 8'h80);
    @(posedge i_clk) i_battery_low <= 1'b1;
    rchk(`ADDR_CTRL1, 8'h01, 8'h01, "lowbat");
    host.wr(`ADDR_CTRL1, 8'h00);
    @(posedge i_clk) i_battery_low <= 1'b0;
    rchk(`ADDR_CTRL1, 8'h01, 8'h01, "lowbat_frz");
    host.wr(`ADDR_CTRL1, 8'h80);
    rchk(`ADDR_CTRL1, 8'h00, 8'h01, "lowbat_new");
    $display("done t_lowbat");
end
endtask
// power loss with no delay, delay cut short, or delay run out
task t_pf(input bit dly, input bit clr);
reg [7:0] rt;
begin
    rt = (dly && !clr) ? 8'h80 : 8'h00;
    host.wr(`ADDR_RT_MODE, {1'b0, rt[7], rt[7], 5'h10});
    host.wr(`ADDR_ROUTING, {dly, 7'h00});
    if (!dly)
    begin
        @(posedge i_clk) i_power_loss_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_power_loss_n <= 1'b1;
        repeat (20) @(negedge i_clk);
        chk("glitch", 0, o_lockout);
    end
    @(posedge i_clk) i_power_loss_n <= 1'b0;
    wait_lock(1, clr ? DEB + 8 : 200);
    if (!dly)
    begin
        chk("lock_t", 1, n >= DEB && n <= 2 * DEB);
        chk("irq", 1, o_irq_out);
    end
    else if (!clr)
        chk("grace_t", 1, n >= DEB + GRC && n <= DEB + GRC + 12);
    else
    begin
        chk("grace", 0, o_lockout);
        rchk(`ADDR_MAIN_STATUS, 8'h02, 8'h02, "pf_flag");
        host.wr(`ADDR_ROUTING, 8'h00);
        wait_lock(1, 6);
        chk("early", 1, o_lockout);
    end
    chk("tmr_run", rt[7], o_timers_run);
    chk("int_run", rt[7], o_ints_run);
    host.wr(`ADDR_ROUTING, ~rt);
    host.rd(`ADDR_ROUTING, q, oe);
    chk("lock_oe_n", 1, oe);
    @(posedge i_clk) i_power_loss_n <= 1'b1;
    wait_lock(0, 200);
    chk("unlock_t", 1, n >= DEB && n <= 2 * DEB);
    rchk(`ADDR_ROUTING, rt, 8'hFF, "rt_kept");
    rchk(`ADDR_MAIN_STATUS, 8'h00, 8'h02, "pf_gone");
    $display("done t_pf");
end
endtask
// a strobe stuck across a failure forces lockout long before the grace
// period would; the interrupt is masked but lockout must still happen
task t_hold;
begin
    host.wr(`ADDR_CTRL1, 8'h00);
    host.wr(`ADDR_ROUTING, 8'h80);
    @(posedge i_clk) i_power_loss_n <= 1'b0;
    host.stall(`ADDR_ROUTING, 20, 20);
    chk("hold_lock", 1, o_lockout);
    chk("irq_mask", 0, o_irq_out);
    @(posedge i_clk) i_power_loss_n <= 1'b1;
    wait_lock(0, 200);
    chk("hold_unlock", 0, o_lockout);
    $display("done t_hold");
end
endtask
// hang guard: the whole run needs well under this many cycles
always @(posedge i_clk)
begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
        bad_count = bad_count + 1;
        complete_run;
    end
end
initial
begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (20) @(posedge i_clk);
    t_reset;
    t_standby;
    t_lowbat;
    t_pf(0, 0);
    t_pf(1, 1);
    t_pf(1, 0);
    t_hold;
    complete_run;
end
endmodule
